/* File: rtl/pbsp_pkg.sv */
package pbsp_pkg;

    // Transfer size encodings on the two-bit size input.
    localparam logic [1:0] SIZE_WORD = 2'h0;
    localparam logic [1:0] SIZE_BYTE = 2'h1;
    localparam logic [1:0] SIZE_HALF = 2'h2;

    // Port width selections.
    localparam logic [1:0] WIDTH_8 = 2'h0;
    localparam logic [1:0] WIDTH_16 = 2'h1;
    localparam logic [1:0] WIDTH_32 = 2'h2;

    // Field widths.
    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;
    localparam int LANES = 4;

    // Reset values.
    localparam logic [31:0] DATA_RST = 32'h0000_0000;
    localparam logic [3:0] MASK_RST = 4'h0;

    // Request passed from the port domain to the system side.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic write;
        logic [1:0] size;
        logic [DATA_W-1:0] wdata;
        logic [LANES-1:0] lane_en;
        logic burst;
    } pbsp_req_type;

    // Answer returned from the system side.
    typedef struct packed {
        logic [DATA_W-1:0] rdata;
        logic error;
        logic retry;
    } pbsp_rsp_type;

endpackage

/* File: rtl/pbsp_port.sv */
`timescale 1ns/10ps
`default_nettype none
//Contract
// [RULE_01] Master asserts burst-data-in-progress; negation aborts burst. Here burst_data_in_progress is unused and nothing aborts.
// [RULE_02] Size 01 byte, 10 half, 00 word.
// [RULE_03] Acknowledge low after write accepted or read data.
// [RULE_04] All signalling on rising port bus clock.
// [RULE_05] System error gives transfer error acknowledge low.
// [RULE_06] Port may request retry; master repeats cycle.
// [RULE_07] Data width selectable 8, 16, 32.
// [RULE_08] Port drives data only during reads.
// [RULE_09] Parity width 1/2/4, one bit per lane.
// [RULE_10] Master drives low address bits 14..31.
// [RULE_11] Burst indicator low during burst transfers.
// [RULE_12] Direction high read, low write.
// [RULE_13] Strobe marks each transaction presented.
// [RULE_14] Exactly one termination response per transaction.
// [RULE_15] Narrow widths use lowest lanes only.
module pbsp_port (
    input wire logic port_bus_clock,
    input wire logic port_srst,
    input wire logic [pbsp_pkg::ADDR_W-1:0] port_address_bus,
    input wire logic read_write_dir,
    input wire logic transfer_strobe,
    input wire logic [1:0] transfer_size,
    input wire logic burst_indicator_n,
    input wire logic burst_data_in_progress,
    input wire logic [pbsp_pkg::DATA_W-1:0] data_in,
    output logic [pbsp_pkg::DATA_W-1:0] data_out,
    output logic [pbsp_pkg::LANES-1:0] data_oe,
    input wire logic [pbsp_pkg::LANES-1:0] lane_parity_in,
    output logic [pbsp_pkg::LANES-1:0] lane_parity_out,
    output logic [pbsp_pkg::LANES-1:0] lane_parity_oe,
    output logic transfer_ack_n,
    output logic transfer_error_ack_n,
    output logic retry_request,
    output logic parity_error,
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [1:0] width_sel,
    input wire logic retry_force,
    output logic sys_req_valid,
    output pbsp_pkg::pbsp_req_type sys_req,
    input wire logic sys_rsp_valid,
    input wire pbsp_pkg::pbsp_rsp_type sys_rsp,
    output logic busy
);

    // Port-domain phases of one transaction.
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_WAIT = 4'h2,
        ST_TERM = 4'h4,
        ST_GAP = 4'h8
    } pbsp_phase_type;

    // Whole port-domain state.
    typedef struct packed {
        pbsp_phase_type phase;
        pbsp_pkg::pbsp_req_type req;
        logic req_tgl;
        logic [pbsp_pkg::DATA_W-1:0] dout;
        logic [pbsp_pkg::LANES-1:0] doe;
        logic [pbsp_pkg::LANES-1:0] pout;
        logic ack_n;
        logic tea_n;
        logic rtry;
        logic perr;
    } pbsp_port_state_type;

    // Whole system-domain state.
    typedef struct packed {
        logic req_seen;
        logic req_valid;
        logic rsp_tgl;
        pbsp_pkg::pbsp_rsp_type rsp;
        logic busy;
    } pbsp_sys_state_type;

    pbsp_port_state_type p_ff;
    pbsp_port_state_type nxt_p;
    pbsp_sys_state_type s_ff;
    pbsp_sys_state_type nxt_s;

    // Crossed toggles and levels.
    logic req_tgl_sys;
    logic rsp_tgl_port;
    logic [1:0] width_port;
    logic retry_port;

    pbsp_sync #(.WIDTH(1)) u_req_sync (
        .clk(sys_clk),
        .rst(srst),
        .d(p_ff.req_tgl),
        .q(req_tgl_sys)
    );

    pbsp_sync #(.WIDTH(4)) u_rsp_sync (
        .clk(port_bus_clock),
        .rst(port_srst),
        .d({s_ff.rsp_tgl, retry_force, width_sel}),
        .q({rsp_tgl_port, retry_port, width_port})
    );

    // Lane enables for a given size; narrow widths keep lowest lanes.
    function automatic logic [3:0] lanes_of(input logic [1:0] sz,
                                            input logic [1:0] wd);
        logic [3:0] m;
        m = 4'hF;
        case (sz)
            pbsp_pkg::SIZE_BYTE: m = 4'h1; // [RULE_02]
            pbsp_pkg::SIZE_HALF: m = 4'h3; // [RULE_02]
            default: m = 4'hF; // [RULE_02]
        endcase
        case (wd)
            pbsp_pkg::WIDTH_8: m = m & 4'h1; // [RULE_07] [RULE_15]
            pbsp_pkg::WIDTH_16: m = m & 4'h3; // [RULE_07] [RULE_15]
            default: m = m; // [RULE_07]
        endcase
        return m;
    endfunction

    // Parity per byte lane: bit k covers lane k.
    function automatic logic [3:0] par_of(input logic [31:0] d);
        logic [3:0] p;
        p = 4'h0;
        for (int k = 0; k < 4; k++) begin
            p[k] = ^d[8*k +: 8]; // [RULE_09]
        end
        return p;
    endfunction

    // Port-domain logic, all on the rising port bus clock. // [RULE_04]
    always_comb begin
        logic [3:0] lanes;
        lanes = lanes_of(transfer_size, width_port);
        nxt_p = p_ff;
        nxt_p.ack_n = 1'b1;
        nxt_p.tea_n = 1'b1;
        nxt_p.rtry = 1'b0;
        nxt_p.perr = 1'b0;
        case (p_ff.phase)
            ST_IDLE: begin
                nxt_p.doe = pbsp_pkg::MASK_RST;
                // Strobe marks a new transaction. // [RULE_13]
                if (transfer_strobe) begin
                    nxt_p.req.addr = port_address_bus; // [RULE_10]
                    nxt_p.req.write = ~read_write_dir; // [RULE_12]
                    nxt_p.req.size = transfer_size;
                    nxt_p.req.wdata = data_in;
                    nxt_p.req.lane_en = lanes;
                    nxt_p.req.burst = ~burst_indicator_n; // [RULE_11]
                    // Parity only checked on enabled write lanes.
                    nxt_p.perr = ~read_write_dir &
                        |((par_of(data_in) ^ lane_parity_in) & lanes);
                    if (retry_port) begin
                        nxt_p.rtry = 1'b1; // [RULE_06]
                        nxt_p.phase = ST_GAP;
                    end else begin
                        nxt_p.req_tgl = ~p_ff.req_tgl;
                        nxt_p.phase = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                // Answer arrives as a toggle from the system side.
                if (rsp_tgl_port != p_ff.req_tgl) begin
                    nxt_p.phase = ST_WAIT;
                end else begin
                    nxt_p.phase = ST_TERM;
                end
            end
            ST_TERM: begin
                // One termination only, with error over retry over ack.
                if (s_ff.rsp.error) begin
                    nxt_p.tea_n = 1'b0; // [RULE_05] [RULE_14]
                end else if (s_ff.rsp.retry) begin
                    nxt_p.rtry = 1'b1; // [RULE_06] [RULE_14]
                end else begin
                    nxt_p.ack_n = 1'b0; // [RULE_03] [RULE_14]
                    if (!p_ff.req.write) begin
                        nxt_p.dout = s_ff.rsp.rdata;
                        nxt_p.pout = par_of(s_ff.rsp.rdata); // [RULE_09]
                        nxt_p.doe = p_ff.req.lane_en; // [RULE_08]
                    end
                end
                nxt_p.phase = ST_GAP;
            end
            ST_GAP: begin
                // Release the bus; wait for strobe to drop.
                nxt_p.doe = pbsp_pkg::MASK_RST; // [RULE_08]
                if (!transfer_strobe) begin
                    nxt_p.phase = ST_IDLE;
                end
            end
            default: begin
                nxt_p.phase = ST_IDLE;
            end
        endcase
        // Beats of a burst are each their own strobed access. // [RULE_01]
    end

    // Port-domain register.
    always_ff @(posedge port_bus_clock) begin
        if (port_srst) begin
            p_ff <= '{phase: ST_IDLE, ack_n: 1'b1, tea_n: 1'b1,
                      default: '0};
        end else begin
            p_ff <= nxt_p;
        end
    end

    // The answer word is held stable by the system side until the
    // toggle has crossed, so reading it here after the sync is safe.

    // System-domain logic: detect request toggle, issue and answer.
    always_comb begin
        nxt_s = s_ff;
        nxt_s.req_seen = req_tgl_sys;
        if (req_tgl_sys != s_ff.req_seen) begin
            nxt_s.req_valid = 1'b1;
            nxt_s.busy = 1'b1;
        end
        if (s_ff.req_valid && sys_rsp_valid) begin
            nxt_s.req_valid = 1'b0;
            nxt_s.rsp = sys_rsp; // [RULE_05]
            nxt_s.rsp_tgl = req_tgl_sys;
            nxt_s.busy = 1'b0;
        end
    end

    // System-domain register.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign data_out = p_ff.dout;
    assign data_oe = p_ff.doe;
    assign lane_parity_out = p_ff.pout;
    assign lane_parity_oe = p_ff.doe;
    assign transfer_ack_n = p_ff.ack_n;
    assign transfer_error_ack_n = p_ff.tea_n;
    assign retry_request = p_ff.rtry;
    assign parity_error = p_ff.perr;
    assign sys_req_valid = s_ff.req_valid;
    assign sys_req = p_ff.req;
    assign busy = s_ff.busy;

    // Never acknowledge together with error acknowledge or with retry.
    a_one_term: assert property (@(posedge port_bus_clock)
        disable iff (port_srst)
        !((!transfer_ack_n) && (!transfer_error_ack_n))
        && !(retry_request && !transfer_ack_n))
        else $error("two terminations at once"); // [RULE_14]

    // Data lanes driven only with a read acknowledge.
    a_read_drive: assert property (@(posedge port_bus_clock)
        disable iff (port_srst)
        (data_oe != 4'h0) |-> (!transfer_ack_n && !p_ff.req.write))
        else $error("data driven outside read"); // [RULE_08]

    // Acknowledge is a single-cycle low pulse.
    a_ack_pulse: assert property (@(posedge port_bus_clock)
        disable iff (port_srst)
        !transfer_ack_n |=> transfer_ack_n)
        else $error("ack held too long"); // [RULE_03]

    // Error acknowledge only after a terminating step.
    a_err_cause: assert property (@(posedge port_bus_clock)
        disable iff (port_srst)
        !transfer_error_ack_n |-> $past(p_ff.phase) == ST_TERM)
        else $error("error ack without cause"); // [RULE_05]

    // Eight-bit width enables lane zero only.
    a_narrow_lane: assert property (@(posedge port_bus_clock)
        disable iff (port_srst)
        (width_port == pbsp_pkg::WIDTH_8) && $stable(width_port)
        |=> (data_oe & 4'hE) == 4'h0)
        else $error("upper lanes used at 8-bit width"); // [RULE_15]

    // Byte size enables one lane.
    a_size_byte: assert property (@(posedge port_bus_clock)
        disable iff (port_srst)
        (p_ff.phase == ST_IDLE) && transfer_strobe
        && (transfer_size == pbsp_pkg::SIZE_BYTE)
        |=> (p_ff.req.lane_en == 4'h1) || retry_request)
        else $error("byte size lanes wrong"); // [RULE_02]

    // Read parity matches driven data on lane zero.
    a_par_lane: assert property (@(posedge port_bus_clock)
        disable iff (port_srst)
        data_oe[0] |-> lane_parity_out[0] == ^data_out[7:0])
        else $error("lane parity wrong"); // [RULE_09]

    // Retry forced at strobe answers in one cycle.
    a_retry_fast: assert property (@(posedge port_bus_clock)
        disable iff (port_srst)
        (p_ff.phase == ST_IDLE) && transfer_strobe && retry_port
        |=> retry_request ##1 transfer_ack_n)
        else $error("retry not given"); // [RULE_06]

endmodule
`default_nettype wire

/* File: rtl/pbsp_sync.sv */
`timescale 1ns/10ps
`default_nettype none
// Two-flop level synchroniser; the first stage is read only by the second.
module pbsp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    // Both stages held in one packed record.
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } pbsp_sync_state_type;

    pbsp_sync_state_type st_ff;
    pbsp_sync_state_type nxt_st;

    // A zero-width synchroniser would carry nothing across.
    if (WIDTH < 1) begin : g_bad_width
        $error("pbsp_sync needs WIDTH of at least one");
    end

    // Shift the level through the two stages.
    always_comb begin
        nxt_st.meta = d;
        nxt_st.sync = st_ff.meta;
    end

    // Register stage with synchronous reset.
    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff.sync;

endmodule
`default_nettype wire

/* File: tb/pbsp_master.sv */
`timescale 1ns/10ps
`default_nettype none
// Behavioural model of the external processor that masters the port.
module pbsp_master (
    input wire logic clk,
    output logic [pbsp_pkg::ADDR_W-1:0] addr,
    output logic rw,
    output logic strobe,
    output logic [1:0] size,
    output logic burst_n,
    output logic bdip,
    output logic [31:0] wdata,
    output logic [3:0] wpar,
    input wire logic [31:0] bus,
    input wire logic ack_n,
    input wire logic tea_n,
    input wire logic retry
);
    // Idle bus: nothing presented, data lines released.
    initial begin
        addr = 18'h00000;
        rw = 1'b1;
        strobe = 1'b0;
        size = 2'h0;
        burst_n = 1'b1;
        bdip = 1'b0;
        wdata = 32'h00000000;
        wpar = 4'h0;
    end

    // One cycle; term is 0 ack, 1 error, 2 retry, 3 none or several at once.
    task automatic xfer(input logic r, input logic [1:0] sz,
        input logic [17:0] a, input logic [31:0] d, input logic bst,
        output logic [1:0] term, output logic [31:0] q);
        int n;
        int hits;
        n = 0;
        term = 2'h3;
        @(negedge clk);
        addr = a;
        rw = r;
        size = sz;
        burst_n = ~bst;
        bdip = bst;
        // On reads the lines are released, so show the inverse of last.
        wdata = r ? ~wdata : d;
        for (int k = 0; k < 4; k++) begin
            wpar[k] = r ? ~wpar[k] : ^d[8*k+:8];
        end
        strobe = 1'b1;
        // Hold everything until a termination is sampled on a rising edge.
        while (term == 2'h3 && n < 400) begin
            @(posedge clk);
            n++;
            hits = int'(!ack_n) + int'(!tea_n) + int'(retry);
            q = bus;
            if (ack_n === 1'b0) term = 2'h0;
            else if (tea_n === 1'b0) term = 2'h1;
            else if (retry === 1'b1) term = 2'h2;
            if (hits > 1) term = 2'h3;
        end
        @(negedge clk);
        strobe = 1'b0;
        bdip = 1'b0;
        wdata = ~wdata;
        wpar = ~wpar;
        // Strobe must stay low a full cycle before the next request.
        @(negedge clk);
    endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam logic [31:0] RD_PAT = 32'hA53C_96E1;
    logic port_bus_clock = 1'b0, port_srst = 1'b1, sys_clk = 1'b0, srst = 1'b1;
    logic [17:0] port_address_bus;
    logic read_write_dir, transfer_strobe, burst_indicator_n;
    logic burst_data_in_progress, transfer_ack_n, transfer_error_ack_n;
    logic retry_request, parity_error, retry_force = 1'b0;
    logic sys_req_valid, sys_rsp_valid = 1'b0, busy;
    logic [1:0] transfer_size, width_sel = 2'h2, rsp_kind = 2'h0;
    logic [31:0] data_in, data_out, m_data;
    logic [3:0] data_oe, lane_parity_in, lane_parity_out, lane_parity_oe;
    logic [3:0] m_par, ack_oe, ack_par, ack_poe;
    pbsp_pkg::pbsp_req_type sys_req, got_req;
    pbsp_pkg::pbsp_rsp_type sys_rsp = '0;
    int mismatches = 0, tests_run = 0, rsp_wait = 0, req_cnt = 0;

    // The link clock is unrelated in phase to the system clock.
    always #6 port_bus_clock = ~port_bus_clock;
    always #25 sys_clk = ~sys_clk;

    // Wire level of each lane comes from whoever enables it.
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            data_in[8*k+:8] = data_oe[k] ? data_out[8*k+:8]
                                         : m_data[8*k+:8];
            lane_parity_in[k] = lane_parity_oe[k] ? lane_parity_out[k]
                                                  : m_par[k];
        end
    end

    pbsp_master pbsp_master_inst (.clk(port_bus_clock),
        .addr(port_address_bus),
        .rw(read_write_dir), .strobe(transfer_strobe), .size(transfer_size),
        .burst_n(burst_indicator_n), .bdip(burst_data_in_progress),
        .wdata(m_data), .wpar(m_par), .bus(data_in), .ack_n(transfer_ack_n),
        .tea_n(transfer_error_ack_n), .retry(retry_request));

    pbsp_port pbsp_port_inst (.port_bus_clock, .port_srst, .port_address_bus,
        .read_write_dir, .transfer_strobe, .transfer_size, .burst_indicator_n,
        .burst_data_in_progress, .data_in, .data_out, .data_oe, .lane_parity_in,
        .lane_parity_out, .lane_parity_oe, .transfer_ack_n,
        .transfer_error_ack_n,
        .retry_request, .parity_error, .sys_clk, .srst, .width_sel, .retry_force,
        .sys_req_valid, .sys_req, .sys_rsp_valid, .sys_rsp, .busy);

    // Lane enables may only be up in the acknowledge cycle; keep what it shows.
    always @(posedge port_bus_clock) begin
        if (transfer_ack_n === 1'b0) begin
            ack_oe = data_oe;
            ack_par = lane_parity_out;
            ack_poe = lane_parity_oe;
        end else if (data_oe !== 4'h0 || parity_error === 1'b1) begin
            mismatches++;
            $display("BAD data_oe expected 0 seen %h", data_oe);
        end
    end

    // System side: answers each request once, after rsp_wait cycles.
    always begin
        @(posedge sys_clk);
        if (sys_req_valid === 1'b1) begin
            got_req = sys_req;
            req_cnt++;
            repeat (rsp_wait) @(posedge sys_clk);
            @(negedge sys_clk);
            sys_rsp = '{rdata: RD_PAT, error: rsp_kind[0], retry: rsp_kind[1]};
            sys_rsp_valid = 1'b1;
            @(negedge sys_clk);
            sys_rsp_valid = 1'b0;
            sys_rsp = ~sys_rsp;
            while (sys_req_valid === 1'b1) @(posedge sys_clk);
        end
    end

    task automatic chk(input string name, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, e, g);
        end
    endtask

    // Mode pins pass a synchroniser, so give them time to settle.
    task automatic set_mode(input logic [1:0] w, input logic rf,
        input logic [1:0] k);
        @(negedge sys_clk);
        width_sel = w;
        retry_force = rf;
        rsp_kind = k;
        repeat (6) @(posedge port_bus_clock);
    endtask

    // One cycle with its expected termination and lanes in use.
    task automatic run(input logic r, input logic [1:0] sz,
        input logic [17:0] a,
        input logic [31:0] d, input logic bst, input logic [1:0] et,
        input logic [3:0] ln);
        logic [1:0] term;
        logic [31:0] q, m;
        int n0;
        // Count system requests so a stale capture cannot pass.
        n0 = req_cnt;
        pbsp_master_inst.xfer(r, sz, a, d, bst, term, q);
        m = {{8{ln[3]}}, {8{ln[2]}}, {8{ln[1]}}, {8{ln[0]}}};
        chk("term", {30'h0, et}, {30'h0, term});
        chk("busy", 32'h0, {31'h0, busy});
        if (retry_force) begin
            chk("reqs", n0, req_cnt);
            return;
        end
        chk("reqs", n0 + 1, req_cnt);
        chk("lanes", {28'h0, ln}, {28'h0, got_req.lane_en});
        chk("size", {30'h0, sz}, {30'h0, got_req.size});
        chk("dir", {31'h0, ~r}, {31'h0, got_req.write});
        chk("addr", {14'h0, a}, {14'h0, got_req.addr});
        chk("burst", {31'h0, bst}, {31'h0, got_req.burst});
        if (!r) chk("wdata", d & m, got_req.wdata & m);
        if (!r || et != 2'h0) return;
        chk("rdata", RD_PAT & m, q & m);
        chk("oe", {28'h0, ln}, {28'h0, ack_oe});
        chk("par_oe", {28'h0, ln}, {28'h0, ack_poe});
        for (int k = 0; k < 4; k++) begin
            if (ln[k]) begin
                chk("par", {31'h0, ^RD_PAT[8*k+:8]},
                    {31'h0, ack_par[k]});
            end
        end
    endtask

    task automatic t_sizes();
        set_mode(2'h2, 1'b0, 2'h0);
        run(1'b0, 2'h0, 18'h3FFFF, 32'h1234_5678,
            1'b0, 2'h0, 4'hF);
        run(1'b0, 2'h1, 18'h00001, 32'h0000_00C3,
            1'b0, 2'h0, 4'h1);
        run(1'b0, 2'h2, 18'h20000, 32'h0000_BEEF,
            1'b0, 2'h0, 4'h3);
        rsp_wait = 5;
        run(1'b1, 2'h0, 18'h15555, 32'h0, 1'b0, 2'h0, 4'hF);
        rsp_wait = 0;
    endtask

    task automatic t_widths();
        set_mode(2'h0, 1'b0, 2'h0);
        run(1'b1, 2'h0, 18'h00100, 32'h0, 1'b0, 2'h0, 4'h1);
        set_mode(2'h1, 1'b0, 2'h0);
        run(1'b0, 2'h0, 18'h00200, 32'hFACE_0F0F,
            1'b0, 2'h0, 4'h3);
        run(1'b1, 2'h2, 18'h00204, 32'h0, 1'b0, 2'h0, 4'h3);
    endtask

    task automatic t_faults();
        set_mode(2'h2, 1'b0, 2'h1);
        run(1'b1, 2'h0, 18'h00300, 32'h0, 1'b0, 2'h1, 4'hF);
        set_mode(2'h2, 1'b0, 2'h2);
        run(1'b0, 2'h0, 18'h00304, 32'h0BAD_F00D,
            1'b0, 2'h2, 4'hF);
        // Forced retry first, then the master repeats the same cycle.
        set_mode(2'h2, 1'b1, 2'h0);
        run(1'b1, 2'h1, 18'h00308, 32'h0, 1'b0, 2'h2, 4'h1);
        set_mode(2'h2, 1'b0, 2'h0);
        run(1'b1, 2'h1, 18'h00308, 32'h0, 1'b0, 2'h0, 4'h1);
    endtask

    task automatic t_burst();
        run(1'b0, 2'h0, 18'h00400, 32'hC001_D00D,
            1'b1, 2'h0, 4'hF);
        run(1'b1, 2'h0, 18'h00404, 32'h0, 1'b1, 2'h0, 4'hF);
    endtask

    task automatic tally_and_finish();
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Twelve system cycles of reset, port reset released after, then the scenarios.
    initial begin
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        srst = 1'b0;
        // The port reset is a port-domain input, so move it off its edge.
        @(negedge port_bus_clock);
        port_srst = 1'b0;
        repeat (4) @(posedge port_bus_clock);
        t_sizes();
        t_widths();
        t_faults();
        t_burst();
        tally_and_finish();
    end

    // Thirteen short cycles need well under the 20000 system cycles allowed.
    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
